// ### hw/ace_matcher.sv
// module: ace layer-4 field matcher with axi4-lite configuration slave
// Contract
// - source range mode hits only when source port lies within the 16-bit bounds.
// - destination any mode never blocks a hit.
// - destination single mode hits only on equal destination port.
// - destination range mode hits only between lower and upper bound.
// - six tcp flags each have set, unset or don't care condition.
// - set condition requires a tcp frame carrying that flag.
// - unset condition excludes tcp frames carrying that flag.
// - don't care flag has no influence on the hit.
// - service any mode ignores the service field.
// - dscp mode hits only on equal 6-bit dscp.
// - precedence mode hits only on equal 3-bit precedence.
// - icmp any mode places no icmp or protocol restriction.
// - icmp list mode hits only frames with the selected listed type.
// - protocol id mode hits only on equal 8-bit protocol.
// - icmp code is don't care or must equal the defined code.
// - source any mode ignores the source port.
// - hit on a deny entry drops the frame.
// - hit on a permit entry forwards and learns the frame.
`default_nettype none
module ace_matcher (
  input  wire logic            REF_CLK,
  input  wire logic            RESET,
  input  wire logic            AWVALID,
  output logic                 AWREADY,
  input  wire logic [7:0]      AWADDR,
  input  wire logic [2:0]      AWPROT,
  input  wire logic            WVALID,
  output logic                 WREADY,
  input  wire logic [31:0]     WDATA,
  input  wire logic [3:0]      WSTRB,
  output logic                 BVALID,
  input  wire logic            BREADY,
  output logic [1:0]           BRESP,
  input  wire logic            ARVALID,
  output logic                 ARREADY,
  input  wire logic [7:0]      ARADDR,
  input  wire logic [2:0]      ARPROT,
  output logic                 RVALID,
  input  wire logic            RREADY,
  output logic [31:0]          RDATA,
  output logic [1:0]           RRESP,
  input  wire logic            FRAME_VALID,
  input  wire ace_pkg::frame_s FRAME,
  output ace_pkg::result_s     RESULT
);
  // configuration registers
  logic [31:0] ctrl, src_port, dst_port, flags, tos, icmp;
  logic [31:0] next_ctrl, next_src_port, next_dst_port, next_flags, next_tos, next_icmp;
  // bus state
  logic        aw_held, w_held, bvalid, rvalid;
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0]  awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata, rdata, next_rdata;
  logic [3:0]  wstrb, next_wstrb;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  // match state
  ace_pkg::result_s result, next_result;
  logic [31:0] hit_cnt, next_hit_cnt;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~m) | (data & m)) & mask;
  endfunction

  assign AWREADY = !aw_held;
  assign WREADY  = !w_held;
  assign BVALID  = bvalid;
  assign BRESP   = bresp;
  assign ARREADY = !rvalid;
  assign RVALID  = rvalid;
  assign RDATA   = rdata;
  assign RRESP   = rresp;
  assign RESULT  = result;

  // address and data are taken in either order, committed once both are held
  always_comb begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_awaddr   = awaddr;
    next_wdata    = wdata;
    next_wstrb    = wstrb;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_ctrl     = ctrl;
    next_src_port = src_port;
    next_dst_port = dst_port;
    next_flags    = flags;
    next_tos      = tos;
    next_icmp     = icmp;
    if (bvalid && BREADY) begin
      next_bvalid = 1'b0;
    end
    if (AWVALID && !aw_held) begin
      next_aw_held = 1'b1;
      next_awaddr  = AWADDR;
    end
    if (WVALID && !w_held) begin
      next_w_held = 1'b1;
      next_wdata  = WDATA;
      next_wstrb  = WSTRB;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = ace_pkg::RESP_OKAY;
      case ({awaddr[7:2], 2'b00})
        ace_pkg::OFF_CTRL:     next_ctrl     = merge(ctrl, wdata, wstrb, ace_pkg::MASK_CTRL);
        ace_pkg::OFF_SRC_PORT: next_src_port = merge(src_port, wdata, wstrb, ace_pkg::MASK_PORT);
        ace_pkg::OFF_DST_PORT: next_dst_port = merge(dst_port, wdata, wstrb, ace_pkg::MASK_PORT);
        ace_pkg::OFF_FLAGS:    next_flags    = merge(flags, wdata, wstrb, ace_pkg::MASK_FLAGS);
        ace_pkg::OFF_TOS:      next_tos      = merge(tos, wdata, wstrb, ace_pkg::MASK_TOS);
        ace_pkg::OFF_ICMP:     next_icmp     = merge(icmp, wdata, wstrb, ace_pkg::MASK_ICMP);
        // status and counter are read-only: write ignored but acknowledged
        ace_pkg::OFF_STATUS,
        ace_pkg::OFF_HIT_CNT:  next_bresp    = ace_pkg::RESP_OKAY;
        default:               next_bresp    = ace_pkg::RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr   <= 8'h00;
      wdata    <= 32'h0000_0000;
      wstrb    <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= ace_pkg::RESP_OKAY;
      ctrl     <= ace_pkg::RST_CTRL;
      src_port <= ace_pkg::RST_PORT;
      dst_port <= ace_pkg::RST_PORT;
      flags    <= ace_pkg::RST_FLAGS;
      tos      <= ace_pkg::RST_TOS;
      icmp     <= ace_pkg::RST_ICMP;
    end else begin
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      awaddr   <= next_awaddr;
      wdata    <= next_wdata;
      wstrb    <= next_wstrb;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      ctrl     <= next_ctrl;
      src_port <= next_src_port;
      dst_port <= next_dst_port;
      flags    <= next_flags;
      tos      <= next_tos;
      icmp     <= next_icmp;
    end
  end

  // read channel: answer one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && RREADY) begin
      next_rvalid = 1'b0;
    end
    if (ARVALID && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = ace_pkg::RESP_OKAY;
      case ({ARADDR[7:2], 2'b00})
        ace_pkg::OFF_CTRL:     next_rdata = ctrl;
        ace_pkg::OFF_SRC_PORT: next_rdata = src_port;
        ace_pkg::OFF_DST_PORT: next_rdata = dst_port;
        ace_pkg::OFF_FLAGS:    next_rdata = flags;
        ace_pkg::OFF_TOS:      next_rdata = tos;
        ace_pkg::OFF_ICMP:     next_rdata = icmp;
        ace_pkg::OFF_STATUS:   next_rdata = {29'h0, result.learn, result.drop, result.hit};
        ace_pkg::OFF_HIT_CNT:  next_rdata = hit_cnt;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = ace_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= ace_pkg::RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // field decode
  ace_pkg::port_mode_e src_mode, dst_mode;
  ace_pkg::tos_mode_e  tos_mode;
  ace_pkg::icmp_mode_e icmp_mode;
  logic                code_en, deny, entry_en;
  logic [7:0]          list_type;
  logic                src_ok, dst_ok, tos_ok, icmp_ok, code_ok, all_ok;
  logic [5:0]          flag_ok, set_mask, unset_mask;

  assign src_mode  = ace_pkg::port_mode_e'(ctrl[ace_pkg::CTRL_SRC +: 2]);
  assign dst_mode  = ace_pkg::port_mode_e'(ctrl[ace_pkg::CTRL_DST +: 2]);
  assign tos_mode  = ace_pkg::tos_mode_e'(ctrl[ace_pkg::CTRL_TOS +: 2]);
  assign icmp_mode = ace_pkg::icmp_mode_e'(ctrl[ace_pkg::CTRL_ICMP +: 2]);
  assign code_en   = ctrl[ace_pkg::CTRL_CODE];
  assign deny      = ctrl[ace_pkg::CTRL_DENY];
  assign entry_en  = ctrl[ace_pkg::CTRL_EN];
  assign list_type = ace_pkg::ICMP_LIST[{icmp[ace_pkg::ICMP_IDX +: 3], 3'b000} +: 8];

  l4_port_cmp u_src_cmp (
    .mode   (src_mode),
    .lo     (src_port[ace_pkg::PORT_LO +: 16]),
    .hi     (src_port[ace_pkg::PORT_HI +: 16]),
    .port   (FRAME.src_port),
    .has_l4 (FRAME.has_l4),
    .ok     (src_ok)
  );

  l4_port_cmp u_dst_cmp (
    .mode   (dst_mode),
    .lo     (dst_port[ace_pkg::PORT_LO +: 16]),
    .hi     (dst_port[ace_pkg::PORT_HI +: 16]),
    .port   (FRAME.dst_port),
    .has_l4 (FRAME.has_l4),
    .ok     (dst_ok)
  );

  // one tri-state condition per tcp flag, two bits each in the flags register
  for (genvar g = 0; g < ace_pkg::NUM_FLAGS; g++) begin : g_flag
    ace_pkg::flag_cond_e cond;
    assign cond          = ace_pkg::flag_cond_e'(flags[2*g +: 2]);
    assign set_mask[g]   = (cond == ace_pkg::FLAG_SET);
    assign unset_mask[g] = (cond == ace_pkg::FLAG_UNSET);
    always_comb begin
      unique case (cond)
        ace_pkg::FLAG_DONT_CARE: flag_ok[g] = 1'b1;
        ace_pkg::FLAG_SET:       flag_ok[g] = FRAME.is_tcp && FRAME.tcp_flags[g];
        ace_pkg::FLAG_UNSET:     flag_ok[g] = FRAME.is_tcp && !FRAME.tcp_flags[g];
        default:                 flag_ok[g] = 1'b0;
      endcase
    end
  end

  always_comb begin
    unique case (tos_mode)
      ace_pkg::TOS_ANY:        tos_ok = 1'b1;
      ace_pkg::TOS_DSCP_MATCH: tos_ok = FRAME.dscp == tos[ace_pkg::TOS_DSCP +: 6];
      ace_pkg::TOS_PREC_MATCH: tos_ok = FRAME.dscp[ace_pkg::PREC_LSB +: 3] == tos[ace_pkg::TOS_PREC +: 3];
      default:                 tos_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (icmp_mode)
      ace_pkg::ICMP_ANY:         icmp_ok = 1'b1;
      ace_pkg::ICMP_LIST_MATCH:  icmp_ok = FRAME.is_icmp && (FRAME.icmp_type == list_type);
      ace_pkg::ICMP_PROTO_MATCH: icmp_ok = FRAME.proto == icmp[ace_pkg::ICMP_PROT +: 8];
      default:                   icmp_ok = 1'b0;
    endcase
  end

  // a defined code only passes icmp frames with that code
  assign code_ok = !code_en || (FRAME.is_icmp && FRAME.icmp_code == icmp[ace_pkg::ICMP_CODE +: 8]);
  assign all_ok  = src_ok && dst_ok && (&flag_ok) && tos_ok && icmp_ok && code_ok;

  // hit is registered so the forwarding stage sees a clean, timed decision
  always_comb begin
    next_result.valid = FRAME_VALID;
    next_result.hit   = FRAME_VALID && entry_en && all_ok;
    next_result.drop  = FRAME_VALID && entry_en && all_ok && deny;
    next_result.learn = FRAME_VALID && entry_en && all_ok && !deny;
    next_hit_cnt      = next_result.hit ? hit_cnt + 32'h0000_0001 : hit_cnt;
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      result  <= '0;
      hit_cnt <= 32'h0000_0000;
    end else begin
      result  <= next_result;
      hit_cnt <= next_hit_cnt;
    end
  end

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  logic [15:0] src_lo, src_hi, dst_lo, dst_hi;
  assign src_lo = src_port[ace_pkg::PORT_LO +: 16];
  assign src_hi = src_port[ace_pkg::PORT_HI +: 16];
  assign dst_lo = dst_port[ace_pkg::PORT_LO +: 16];
  assign dst_hi = dst_port[ace_pkg::PORT_HI +: 16];

  property p_src_range;
    FRAME_VALID && src_mode == ace_pkg::PORT_RANGE && (FRAME.src_port < src_lo || FRAME.src_port > src_hi)
      |=> RESULT.valid && !RESULT.hit;
  endproperty
  a_src_range: assert property (p_src_range) else $error("source port out of range hit");
  property p_dst_any;
    dst_mode == ace_pkg::PORT_ANY |-> dst_ok;
  endproperty
  a_dst_any: assert property (p_dst_any) else $error("destination any blocked a hit");
  property p_dst_single;
    FRAME_VALID && dst_mode == ace_pkg::PORT_SINGLE && FRAME.dst_port != dst_lo |=> !RESULT.hit;
  endproperty
  a_dst_single: assert property (p_dst_single) else $error("destination single mismatch hit");
  property p_dst_range;
    FRAME_VALID && dst_mode == ace_pkg::PORT_RANGE && (FRAME.dst_port < dst_lo || FRAME.dst_port > dst_hi)
      |=> !RESULT.hit;
  endproperty
  a_dst_range: assert property (p_dst_range) else $error("destination port out of range hit");
  property p_flag_set;
    FRAME_VALID && |(set_mask & ~FRAME.tcp_flags) |=> !RESULT.hit;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("required tcp flag missing but hit");
  property p_flag_unset;
    FRAME_VALID && FRAME.is_tcp && |(unset_mask & FRAME.tcp_flags) |=> !RESULT.hit;
  endproperty
  a_flag_unset: assert property (p_flag_unset) else $error("excluded tcp flag present but hit");
  property p_non_tcp;
    FRAME_VALID && !FRAME.is_tcp && |(set_mask | unset_mask) |=> !RESULT.hit;
  endproperty
  a_non_tcp: assert property (p_non_tcp) else $error("non-tcp frame hit a flag condition");
  property p_dscp;
    FRAME_VALID && tos_mode == ace_pkg::TOS_DSCP_MATCH && FRAME.dscp != tos[ace_pkg::TOS_DSCP +: 6]
      |=> !RESULT.hit;
  endproperty
  a_dscp: assert property (p_dscp) else $error("dscp mismatch hit");
  property p_proto;
    FRAME_VALID && icmp_mode == ace_pkg::ICMP_PROTO_MATCH && FRAME.proto != icmp[ace_pkg::ICMP_PROT +: 8]
      |=> !RESULT.hit;
  endproperty
  a_proto: assert property (p_proto) else $error("protocol id mismatch hit");
  property p_code;
    FRAME_VALID && code_en && FRAME.icmp_code != icmp[ace_pkg::ICMP_CODE +: 8] |=> !RESULT.hit;
  endproperty
  a_code: assert property (p_code) else $error("icmp code mismatch hit");
  property p_action;
    RESULT.hit |-> (RESULT.drop == $past(deny)) && (RESULT.learn == !$past(deny));
  endproperty
  a_action: assert property (p_action) else $error("hit action does not follow entry action");
  property p_timing;
    FRAME_VALID ##1 !FRAME_VALID |-> RESULT.valid ##1 !RESULT.valid && !RESULT.hit;
  endproperty
  a_timing: assert property (p_timing) else $error("hit not valid exactly one cycle after frame");
  property p_all_hit;
    FRAME_VALID && entry_en && all_ok |=> RESULT.hit && hit_cnt == $past(hit_cnt) + 32'h0000_0001;
  endproperty
  a_all_hit: assert property (p_all_hit) else $error("all conditions met but no hit");
  c_hit_deny: cover property (RESULT.hit && RESULT.drop);
  c_hit_learn: cover property (RESULT.hit && RESULT.learn);
  c_range_hit: cover property (FRAME_VALID && src_mode == ace_pkg::PORT_RANGE && all_ok && entry_en);
  c_write_read: cover property (bvalid && BREADY ##[1:4] rvalid && RREADY);
endmodule
`default_nettype wire

// ### hw/ace_pkg.sv
// package: register map, field layout and carrier types of the ace layer-4 field matcher
`default_nettype none
package ace_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SRC_PORT = 8'h04;
  localparam logic [7:0] OFF_DST_PORT = 8'h08;
  localparam logic [7:0] OFF_FLAGS    = 8'h0c;
  localparam logic [7:0] OFF_TOS      = 8'h10;
  localparam logic [7:0] OFF_ICMP     = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_HIT_CNT  = 8'h1c;

  // writable bits of each register; all others read as zero
  localparam logic [31:0] MASK_CTRL  = 32'h0000_07ff;
  localparam logic [31:0] MASK_PORT  = 32'hffff_ffff;
  localparam logic [31:0] MASK_FLAGS = 32'h0000_0fff;
  localparam logic [31:0] MASK_TOS   = 32'h0000_073f;
  localparam logic [31:0] MASK_ICMP  = 32'h00ff_ff07;

  // reset values
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_PORT  = 32'h0000_0000;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [31:0] RST_TOS   = 32'h0000_0000;
  localparam logic [31:0] RST_ICMP  = 32'h0000_0000;

  // field positions in ctrl
  localparam int unsigned CTRL_EN   = 0;
  localparam int unsigned CTRL_DENY = 1;
  localparam int unsigned CTRL_SRC  = 2;
  localparam int unsigned CTRL_DST  = 4;
  localparam int unsigned CTRL_TOS  = 6;
  localparam int unsigned CTRL_ICMP = 8;
  localparam int unsigned CTRL_CODE = 10;
  // field positions in the port, tos and icmp registers
  localparam int unsigned PORT_LO   = 0;
  localparam int unsigned PORT_HI   = 16;
  localparam int unsigned TOS_DSCP  = 0;
  localparam int unsigned TOS_PREC  = 8;
  localparam int unsigned ICMP_IDX  = 0;
  localparam int unsigned ICMP_PROT = 8;
  localparam int unsigned ICMP_CODE = 16;
  // dscp bits that form the precedence
  localparam int unsigned PREC_LSB  = 3;
  localparam int unsigned NUM_FLAGS = 6;

  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // predefined icmpv6 type list, entry n in bits [8n+7:8n]
  localparam logic [63:0] ICMP_LIST = 64'h8685_8180_0403_0201;

  typedef enum logic [1:0] {PORT_ANY, PORT_SINGLE, PORT_RANGE} port_mode_e;
  typedef enum logic [1:0] {FLAG_DONT_CARE, FLAG_SET, FLAG_UNSET} flag_cond_e;
  typedef enum logic [1:0] {TOS_ANY, TOS_DSCP_MATCH, TOS_PREC_MATCH} tos_mode_e;
  typedef enum logic [1:0] {ICMP_ANY, ICMP_LIST_MATCH, ICMP_PROTO_MATCH} icmp_mode_e;

  // parsed header fields from the ingress parser; tcp_flags is urg,ack,psh,rst,syn,fin
  typedef struct packed {
    logic        is_tcp;
    logic        has_l4;
    logic        is_icmp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [5:0]  tcp_flags;
    logic [5:0]  dscp;
    logic [7:0]  proto;
    logic [7:0]  icmp_type;
    logic [7:0]  icmp_code;
  } frame_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic drop;
    logic learn;
  } result_s;
endpackage
`default_nettype wire

// ### hw/l4_port_cmp.sv
// module: one layer-4 port condition (any, single or range)
`default_nettype none
module l4_port_cmp (
  input  wire ace_pkg::port_mode_e mode,
  input  wire logic [15:0]         lo,
  input  wire logic [15:0]         hi,
  input  wire logic [15:0]         port,
  input  wire logic                has_l4,
  output logic                     ok
);
  always_comb begin
    unique case (mode)
      ace_pkg::PORT_ANY:    ok = 1'b1;
      ace_pkg::PORT_SINGLE: ok = has_l4 && (port == lo);
      ace_pkg::PORT_RANGE:  ok = has_l4 && (port >= lo) && (port <= hi);
      // reserved encoding never hits
      default:              ok = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### tb/frame_source.sv
// partner model: behavioural ingress parser presenting parsed frames
`default_nettype none
module frame_source (
  input  wire logic            clk,
  input  wire logic            go,
  input  wire ace_pkg::frame_s f,
  output logic                 frame_valid,
  output var ace_pkg::frame_s  frame
);
  timeunit 1ns;
  timeprecision 1ps;
  ace_pkg::frame_s last = '0;
  always @(posedge clk) begin
    if (go) begin
      last <= f;
    end
  end
  // idle bus shows the inverse of the last frame, so a stale sample cannot pass
  assign frame_valid = go;
  assign frame       = go ? f : ~last;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench: axi4-lite configuration and frame match checks of the ace matcher
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic            ref_clk, reset, go, deny, fv;
  logic            awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp;
  ace_pkg::frame_s f, fr, b, x;
  ace_pkg::result_s res;
  int              fail_count, n_checks, cycles, hits;
  logic [15:0]     sp[4] = '{16'h0063, 16'h0064, 16'h00c8, 16'h00c9};
  logic [15:0]     dp[5] = '{16'hffff, 16'hfffe, 16'h0000, 16'h0005, 16'h0006};

  ace_matcher ace_matcher_inst (.REF_CLK(ref_clk), .RESET(reset), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
    .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .FRAME_VALID(fv),
    .FRAME(fr), .RESULT(res));
  frame_source frame_source_inst (.clk(ref_clk), .go(go), .f(f), .frame_valid(fv), .frame(fr));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = ace_pkg::RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    // no local limit: only the bench timeout ends a hung wait
    forever begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = ace_pkg::RESP_OKAY);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  // entry enabled; modes: source, destination, service, icmp, code defined
  task automatic cfg(input int s, input int d, input int t, input int i, input int c);
    wr(ace_pkg::OFF_CTRL, 32'h1 | (32'(deny) << ace_pkg::CTRL_DENY) | (32'(s) << ace_pkg::CTRL_SRC)
       | (32'(d) << ace_pkg::CTRL_DST) | (32'(t) << ace_pkg::CTRL_TOS) | (32'(i) << ace_pkg::CTRL_ICMP)
       | (32'(c) << ace_pkg::CTRL_CODE));
  endtask

  // one frame, result expected exactly one edge later
  task automatic send(input ace_pkg::frame_s y, input logic eh);
    @(posedge ref_clk);
    go <= 1'b1;
    f  <= y;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    chk("result", {28'h0, 1'b1, eh, eh & deny, eh & ~deny}, 32'(res));
    if (eh) hits++;
  endtask

  initial begin
    reset = 1'b1;
    go = 1'b0;
    f = '0;
    deny = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {fail_count, n_checks, cycles, hits} = '0;
    b = {3'b111, 16'h0, 16'h0, 6'h0, 6'h0, 8'h06, 8'h01, 8'h00};
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    // every configuration register resets to zero
    for (int k = 0; k < 6; k++) rd(8'(4 * k), 32'h0);
    rd(8'h20, 32'h0, ace_pkg::RESP_DECERR);
    wr(8'h20, 32'h1, ace_pkg::RESP_DECERR);
    wr(ace_pkg::OFF_TOS, 32'hffff_ffff);
    rd(ace_pkg::OFF_TOS, ace_pkg::MASK_TOS);
    // one byte lane leaves the other lanes as they were
    wr(ace_pkg::OFF_TOS, 32'h0000_0000, ace_pkg::RESP_OKAY, 4'h1);
    rd(ace_pkg::OFF_TOS, 32'h0000_0700);
    wr(ace_pkg::OFF_HIT_CNT, 32'hffff_ffff);
    x = b;
    send(x, 1'b0);
    $display("test registers done");
    cfg(0, 0, 0, 0, 0);
    send(x, 1'b1);
    deny = 1'b1;
    cfg(0, 0, 0, 0, 0);
    send(x, 1'b1);
    deny = 1'b0;
    $display("test action done");
    wr(ace_pkg::OFF_SRC_PORT, {16'h00c8, 16'h0064});
    cfg(2, 0, 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      x.src_port = sp[k];
      send(x, k == 1 || k == 2);
    end
    x.has_l4 = 1'b0;
    x.src_port = 16'h0096;
    send(x, 1'b0);
    x = b;
    wr(ace_pkg::OFF_DST_PORT, 32'h0000_ffff);
    cfg(0, 1, 0, 0, 0);
    for (int k = 0; k < 5; k++) begin
      if (k == 2) begin
        wr(ace_pkg::OFF_DST_PORT, 32'h0005_0000);
        cfg(0, 2, 0, 0, 0);
      end
      x.dst_port = dp[k];
      send(x, k != 1 && k != 4);
    end
    $display("test ports done");
    x = b;
    cfg(0, 0, 0, 0, 0);
    for (int n = 0; n < ace_pkg::NUM_FLAGS; n++) begin
      wr(ace_pkg::OFF_FLAGS, 32'h1 << (2 * n));
      x.tcp_flags = 6'(1 << n);
      send(x, 1'b1);
      x.tcp_flags = 6'h3f ^ 6'(1 << n);
      send(x, 1'b0);
      wr(ace_pkg::OFF_FLAGS, 32'h2 << (2 * n));
      send(x, 1'b1);
      x.tcp_flags = 6'(1 << n);
      send(x, 1'b0);
    end
    wr(ace_pkg::OFF_FLAGS, 32'h1);
    x.is_tcp = 1'b0;
    x.tcp_flags = 6'h01;
    send(x, 1'b0);
    wr(ace_pkg::OFF_FLAGS, 32'h0);
    $display("test flags done");
    x = b;
    wr(ace_pkg::OFF_TOS, 32'h0000_073f);
    cfg(0, 0, 1, 0, 0);
    x.dscp = 6'h3f;
    send(x, 1'b1);
    x.dscp = 6'h3e;
    send(x, 1'b0);
    cfg(0, 0, 2, 0, 0);
    x.dscp = 6'h38;
    send(x, 1'b1);
    x.dscp = 6'h30;
    send(x, 1'b0);
    $display("test service done");
    x = b;
    cfg(0, 0, 0, 1, 0);
    for (int k = 0; k < 8; k++) begin
      wr(ace_pkg::OFF_ICMP, 32'(k));
      x.icmp_type = ace_pkg::ICMP_LIST[8 * k +: 8];
      send(x, 1'b1);
      x.icmp_type = ace_pkg::ICMP_LIST[8 * ((k + 1) % 8) +: 8];
      send(x, 1'b0);
    end
    x = b;
    wr(ace_pkg::OFF_ICMP, 32'h00ff_ff00);
    cfg(0, 0, 0, 2, 0);
    x.proto = 8'hff;
    send(x, 1'b1);
    x.proto = 8'hfe;
    send(x, 1'b0);
    cfg(0, 0, 0, 0, 1);
    x.icmp_code = 8'hff;
    send(x, 1'b1);
    x.icmp_code = 8'h00;
    send(x, 1'b0);
    $display("test icmp done");
    // back-to-back frames: each result lands one edge after its own strobe
    x = b;
    cfg(0, 1, 0, 0, 0);
    @(posedge ref_clk);
    go <= 1'b1;
    f  <= x;
    x.dst_port = 16'h0001;
    @(posedge ref_clk);
    f <= x;
    #1;
    chk("result", 32'hd, 32'(res));
    hits++;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    chk("result", 32'h8, 32'(res));
    rd(ace_pkg::OFF_HIT_CNT, 32'(hits));
    $display("test burst done");
    // a reset in mid-run clears the entry and the hit count
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ace_pkg::OFF_CTRL, 32'h0000_0000);
    rd(ace_pkg::OFF_HIT_CNT, 32'h0000_0000);
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire
